// *** hw/pesa_pkg.sv ***
// package for the pulse energy sync accumulator: register map, fields, codes
// assumes a 32-bit AXI4-Lite register bus with byte addressing
package pesa_pkg;
    // ============================================================
    // register indices (printed offsets), byte address width and accumulator width
    localparam logic [15:0] PESA_IDX_SIGN = 16'hE617;
    localparam logic [15:0] PESA_IDX_ACCUMULATION_MODE_SELECT = 16'hE701;
    localparam logic [15:0] PESA_IDX_LATCH = 16'hE705;
    localparam logic [15:0] PESA_IDX_PCFG = 16'hE610;
    localparam logic [15:0] PESA_IDX_COMP = 16'hE60E;
    localparam logic [15:0] PESA_IDX_FLAGS = 16'hE502;
    localparam logic [15:0] PESA_IDX_ENABLE = 16'hE50A;
    localparam logic [15:0] PESA_IDX_HOUR0 = 16'hF000;
    localparam int PESA_AW = 18;
    localparam int PESA_EW = 32;
    // ============================================================
    // field positions
    localparam int PESA_SEL_W = 3;
    localparam int PESA_DIS_LSB = 9;
    localparam int PESA_LATCH_LSB = 12;
    localparam int PESA_ACT_LSB = 0;
    localparam int PESA_REA_LSB = 2;
    localparam int PESA_FLAG_P1 = 9;
    localparam int PESA_FLAG_P2 = 13;
    localparam int PESA_FLAG_P3 = 18;
    localparam int PESA_SIGN_P1 = 3;
    localparam int PESA_SIGN_P2 = 7;
    localparam int PESA_SIGN_P3 = 8;
    // ============================================================
    // reset values
    localparam logic [15:0] PESA_PCFG_RST = 16'h0E88;
    localparam logic [8:0] PESA_COMP_RST = 9'h1FF;
    localparam logic [7:0] PESA_ACC_RST = 8'h00;
    localparam logic [7:0] PESA_LATCH_RST = 8'h00;
    // ============================================================
    // power type codes
    localparam logic [2:0] PESA_PT_ACT = 3'h0;
    localparam logic [2:0] PESA_PT_REA = 3'h1;
    localparam logic [2:0] PESA_PT_APP = 3'h2;
    localparam logic [2:0] PESA_PT_FACT = 3'h3;
    localparam logic [2:0] PESA_PT_FREA = 3'h4;
    // accumulation mode codes, then bus response codes
    localparam logic [1:0] PESA_M_SIGNED = 2'h0;
    localparam logic [1:0] PESA_M_POS = 2'h1;
    localparam logic [1:0] PESA_M_ADJ = 2'h2;
    localparam logic [1:0] PESA_M_ABS = 2'h3;
    localparam logic [1:0] PESA_RESP_OK = 2'h0;
    localparam logic [1:0] PESA_RESP_ERR = 2'h2;
endpackage : pesa_pkg

// *** hw/pesa_top.sv ***
// pulse energy sync accumulator: accumulation modes, latching, sign events
// assumes per-phase power samples with a valid strobe, first-stage threshold
// strobes and pulse converter levels from the neighbouring divider
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module pesa_top
    import pesa_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // power samples: 5 types x 3 phases, 24-bit signed, packed type-major
    input wire logic I_PWR_VALID,
    input wire logic [359:0] I_PWR,
    input wire logic [2:0] I_ACT_IDLE,
    // first-stage threshold hit and pulse-path sign per converter
    input wire logic [2:0] I_STAGE1_HIT,
    input wire logic [2:0] I_STAGE1_NEG,
    input wire logic [2:0] I_CONV_OUT,
    output logic [2:0] O_PULSE_OUT_N,
    output logic O_EVENT_LINE_0_N,
    output logic [47:0] O_PATH_PWR,
    input wire logic [PESA_AW-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [PESA_AW-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY
);
    // ============================================================
    // helpers
    function automatic logic [PESA_AW-1:0] baddr(input logic [15:0] idx);
        baddr = {idx, 2'b00};
    endfunction : baddr

    function automatic logic signed [23:0] apply_mode(input logic signed [23:0] p,
            input logic [1:0] m, input logic act_neg, input logic is_reg);
        logic signed [23:0] r;
        r = p;
        unique case (m)
            PESA_M_POS: r = (is_reg && p < 0) ? 24'sh000000 : p;
            PESA_M_ABS: r = (p < 0) ? -p : p;
            default: r = p;
        endcase
        apply_mode = r;
    endfunction : apply_mode

    // ============================================================
    // registers
    logic [15:0] pcfg_r;
    logic [8:0] comp_r;
    logic [7:0] accm_r;
    logic [7:0] latch_cnt_r;
    logic [31:0] flags_r, flags_nxt;
    logic [31:0] enable_r;
    logic [15:0] sign_r, sign_nxt;
    logic [2:0] conv_q_r;
    logic [7:0] edge_cnt_r [3];
    logic [2:0] stage_neg_r;
    logic [2:0] change_pend_r;
    logic signed [PESA_EW-1:0] acc_r [15];
    logic signed [PESA_EW-1:0] hour_r [15];

    // ============================================================
    // field decode
    wire [1:0] act_mode = accm_r[PESA_ACT_LSB +: 2];
    wire [1:0] rea_mode = accm_r[PESA_REA_LSB +: 2];
    wire [2:0] pin_dis = pcfg_r[PESA_DIS_LSB +: 3];
    wire [2:0] latch_en = pcfg_r[PESA_LATCH_LSB +: 3];
    wire [2:0] conv_fall = conv_q_r & ~I_CONV_OUT;
    assign O_PULSE_OUT_N = pin_dis | I_CONV_OUT;

    // ============================================================
    // latch interval: a latch fires when the edge count reaches the interval
    logic [2:0] latch_fire;
    logic [14:0] acc_clear;
    always_comb begin
        acc_clear = '0;
        for (int k = 0; k < 3; k++) begin
            latch_fire[k] = latch_en[k] && conv_fall[k] && (edge_cnt_r[k] + 8'h01 >= latch_cnt_r);
            // all three phases of the family
            if (latch_fire[k] && pcfg_r[k*PESA_SEL_W +: PESA_SEL_W] <= PESA_PT_FREA) begin
                for (int ph = 0; ph < 3; ph++) begin
                    acc_clear[pcfg_r[k*PESA_SEL_W +: PESA_SEL_W]*3 + ph] = 1'b1;
                end
            end
        end
    end

    // ============================================================
    // mode-shaped samples for registers and pulse path
    logic signed [23:0] reg_in [15];
    logic signed [23:0] path_in [15];
    always_comb begin
        for (int t = 0; t < 5; t++) begin
            for (int ph = 0; ph < 3; ph++) begin
                logic signed [23:0] p;
                logic an;
                p = I_PWR[(t*3+ph)*24 +: 24];
                an = ($signed(I_PWR[(((t == 4) ? 3 : 0)*3+ph)*24 +: 24]) < 0) && !I_ACT_IDLE[ph];
                if (t == 0 || t == 3) begin
                    reg_in[t*3+ph] = apply_mode(p, act_mode, an, 1'b1);
                    path_in[t*3+ph] = apply_mode(p, act_mode, an, 1'b0);
                end else if (t == 1 || t == 4) begin
                    reg_in[t*3+ph] = apply_mode(p, (rea_mode == PESA_M_POS) ? PESA_M_SIGNED
                        : rea_mode, an, 1'b1);
                    if (rea_mode == PESA_M_ADJ && an) begin
                        reg_in[t*3+ph] = -p;
                    end
                    path_in[t*3+ph] = reg_in[t*3+ph];
                end else begin
                    reg_in[t*3+ph] = p;
                    path_in[t*3+ph] = p;
                end
            end
        end
    end

    // pulse-path sums over included phases, handed to the first stage
    logic [47:0] path_sum;
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            logic signed [15:0] s;
            logic [2:0] sel;
            s = '0;
            sel = pcfg_r[k*PESA_SEL_W +: PESA_SEL_W];
            for (int ph = 0; ph < 3; ph++) begin
                if (comp_r[k*3+ph] && sel <= PESA_PT_FREA) begin
                    s = s + 16'(path_in[sel*3+ph] >>> 8);
                end
            end
            path_sum[k*16 +: 16] = s;
        end
    end

    // ============================================================
    // accumulators and hour registers
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int i = 0; i < 15; i++) begin
                acc_r[i] <= '0;
                hour_r[i] <= '0;
            end
            O_PATH_PWR <= '0;
        end else if (I_CE) begin
            O_PATH_PWR <= path_sum;
            for (int i = 0; i < 15; i++) begin
                // capture and clear, keeping this cycle's sample
                if (acc_clear[i]) begin
                    hour_r[i] <= acc_r[i];
                    acc_r[i] <= I_PWR_VALID ? PESA_EW'(reg_in[i]) : '0;
                end else if (I_PWR_VALID) begin
                    acc_r[i] <= acc_r[i] + PESA_EW'(reg_in[i]);
                end
            end
        end
    end

    // edge counters between latches
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            conv_q_r <= 3'h7;
            for (int k = 0; k < 3; k++) begin
                edge_cnt_r[k] <= '0;
            end
        end else if (I_CE) begin
            conv_q_r <= I_CONV_OUT;
            for (int k = 0; k < 3; k++) begin
                if (latch_fire[k]) begin
                    edge_cnt_r[k] <= '0;
                end else if (latch_en[k] && conv_fall[k]) begin
                    edge_cnt_r[k] <= edge_cnt_r[k] + 8'h01;
                end
            end
        end
    end

    // ============================================================
    // sign detection, flags and sign register
    localparam int FLAG_POS [3] = '{PESA_FLAG_P1, PESA_FLAG_P2, PESA_FLAG_P3};
    localparam int SIGN_POS [3] = '{PESA_SIGN_P1, PESA_SIGN_P2, PESA_SIGN_P3};
    logic [2:0] flag_set;
    logic [31:0] flag_clr;
    always_comb begin
        flags_nxt = flags_r & ~flag_clr;
        sign_nxt = sign_r;
        for (int k = 0; k < 3; k++) begin
            // flag on falling edge, set wins over clear
            flag_set[k] = conv_fall[k] && change_pend_r[k];
            if (flag_set[k]) begin
                flags_nxt[FLAG_POS[k]] = 1'b1;
                sign_nxt[SIGN_POS[k]] = stage_neg_r[k];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            stage_neg_r <= '0;
            change_pend_r <= '0;
            flags_r <= '0;
            sign_r <= '0;
        end else if (I_CE) begin
            flags_r <= flags_nxt;
            sign_r <= sign_nxt;
            for (int k = 0; k < 3; k++) begin
                // sample sign at each threshold hit
                if (I_STAGE1_HIT[k]) begin
                    stage_neg_r[k] <= I_STAGE1_NEG[k];
                end
                if (I_STAGE1_HIT[k] && I_STAGE1_NEG[k] != stage_neg_r[k]) begin
                    change_pend_r[k] <= 1'b1;
                end else if (flag_set[k]) begin
                    change_pend_r[k] <= 1'b0;
                end
            end
        end
    end

    // masked flags drive the line low
    assign O_EVENT_LINE_0_N = ~|(flags_r & enable_r);

    // ============================================================
    // AXI4-Lite slave: one write, one read at a time
    logic aw_got_r, w_got_r;
    logic [PESA_AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    assign O_AWREADY = !aw_got_r && !O_BVALID;
    assign O_WREADY = !w_got_r && !O_BVALID;
    assign O_ARREADY = !O_RVALID;
    wire wr_go = aw_got_r && w_got_r && !O_BVALID;
    wire wr_hit = wr_go && (awaddr_r == baddr(PESA_IDX_PCFG) || awaddr_r == baddr(PESA_IDX_COMP)
        || awaddr_r == baddr(PESA_IDX_ACCUMULATION_MODE_SELECT) || awaddr_r == baddr(PESA_IDX_LATCH)
        || awaddr_r == baddr(PESA_IDX_FLAGS) || awaddr_r == baddr(PESA_IDX_ENABLE));
    // write-one-to-clear on the event flags
    assign flag_clr = (wr_go && awaddr_r == baddr(PESA_IDX_FLAGS)) ? wdata_r : '0;

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            O_BVALID <= 1'b0;
            O_BRESP <= PESA_RESP_OK;
        end else if (I_CE) begin
            if (I_AWVALID && O_AWREADY) begin
                aw_got_r <= 1'b1;
                awaddr_r <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_got_r <= 1'b1;
                wdata_r <= I_WDATA;
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP <= wr_hit ? PESA_RESP_OK : PESA_RESP_ERR;
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // configuration writes; strobes ignored, whole register written
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pcfg_r <= PESA_PCFG_RST;
            comp_r <= PESA_COMP_RST;
            accm_r <= PESA_ACC_RST;
            latch_cnt_r <= PESA_LATCH_RST;
            enable_r <= '0;
        end else if (I_CE && wr_go) begin
            if (awaddr_r == baddr(PESA_IDX_PCFG)) pcfg_r <= wdata_r[15:0];
            if (awaddr_r == baddr(PESA_IDX_COMP)) comp_r <= wdata_r[8:0];
            if (awaddr_r == baddr(PESA_IDX_ACCUMULATION_MODE_SELECT)) accm_r <= wdata_r[7:0];
            // software must avoid writing here at an edge
            if (awaddr_r == baddr(PESA_IDX_LATCH)) latch_cnt_r <= wdata_r[7:0];
            if (awaddr_r == baddr(PESA_IDX_ENABLE)) enable_r <= wdata_r;
        end
    end

    // read mux; hour registers at a block from PESA_IDX_HOUR0
    wire [15:0] ra_idx = I_ARADDR[PESA_AW-1:2];
    wire [15:0] hr_off = ra_idx - PESA_IDX_HOUR0;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = '0;
        if (ra_idx == PESA_IDX_PCFG) rd_val = {16'h0000, pcfg_r};
        else if (ra_idx == PESA_IDX_COMP) rd_val = {23'h000000, comp_r};
        else if (ra_idx == PESA_IDX_ACCUMULATION_MODE_SELECT) rd_val = {24'h000000, accm_r};
        else if (ra_idx == PESA_IDX_LATCH) rd_val = {24'h000000, latch_cnt_r};
        else if (ra_idx == PESA_IDX_FLAGS) rd_val = flags_r;
        else if (ra_idx == PESA_IDX_ENABLE) rd_val = enable_r;
        else if (ra_idx == PESA_IDX_SIGN) rd_val = {16'h0000, sign_r};
        else if (hr_off < 16'h000F) rd_val = hour_r[hr_off[3:0]];
        else rd_ok = 1'b0;
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RVALID <= 1'b0;
            O_RDATA <= '0;
            O_RRESP <= PESA_RESP_OK;
        end else if (I_CE) begin
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_val;
                O_RRESP <= rd_ok ? PESA_RESP_OK : PESA_RESP_ERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // ============================================================
    // checks
    // an enabled cycle with a falling edge and a pending sign change
    sequence fall_s(int k);
        I_CE && conv_fall[k] && change_pend_r[k];
    endsequence
    line_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        |(flags_r & enable_r) |-> !O_EVENT_LINE_0_N) else $error("event line not low");
    flag_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        fall_s(0) |=> flags_r[PESA_FLAG_P1]) else $error("flag one not set");
    sign_upd_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        fall_s(2) |=> sign_r[PESA_SIGN_P3] == $past(stage_neg_r[2]))
        else $error("sign bit not updated");
    pin_high_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        pin_dis[0] |-> O_PULSE_OUT_N[0]) else $error("disabled pin not high");
    no_latch_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        latch_en == 3'h0 |-> acc_clear == 15'h0000) else $error("latch while disabled");
    hour_cap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        I_CE && acc_clear[0] |=> hour_r[0] == $past(acc_r[0])) else $error("hour not captured");
    pos_only_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        act_mode == PESA_M_POS |-> reg_in[0] >= 0) else $error("negative in positive mode");
    abs_mode_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        act_mode == PESA_M_ABS |-> path_in[0] >= 0) else $error("negative in absolute mode");
    all_ph_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        acc_clear[0] |-> acc_clear[1] && acc_clear[2]) else $error("phase not latched");
endmodule : pesa_top

// *** tb/testbench.sv ***
// =====================================================================
// self-checking bench for the pulse energy sync accumulator
// assumes pesa_top alone, driven over its own ports by this module
`timescale 1ns/1ps
module testbench
    import pesa_pkg::*;
;
    logic clk = 0, rstn = 0, pv = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ce = 1;
    logic [359:0] pwr = '0;
    // converter outputs idle high, so reset release shows no false edge
    logic [2:0] idle = '0, hit = '0, neg = '0, conv = 3'h7;
    logic [17:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd_w;
    logic [2:0] pout;
    logic awr, wrd, bv, arr, rv, evn;
    logic [1:0] bresp, rresp;
    logic [47:0] ppw;
    int bad_count = 0, compares = 0, cyc = 0;
    logic [47:0] rq[$], wq[$];
    logic [49:0] pq[$];
    int kept[5];

    pesa_top dut_u (.I_CLOCK(clk), .I_RSTN(rstn), .I_CE(ce), .I_PWR_VALID(pv), .I_PWR(pwr),
        .I_ACT_IDLE(idle), .I_STAGE1_HIT(hit), .I_STAGE1_NEG(neg), .I_CONV_OUT(conv),
        .O_PULSE_OUT_N(pout), .O_EVENT_LINE_0_N(evn), .O_PATH_PWR(ppw), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
        .O_WREADY(wrd), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara),
        .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd_w), .O_RRESP(rresp), .O_RVALID(rv),
        .I_RREADY(rr));

    always #50 clk = ~clk;

    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [47:0] s, input logic [47:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // =====================================================================
    // monitors: each answer is compared with the oldest note
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            report_and_stop();
        end
        if (rv === 1'b1 && rr === 1'b1) check("read", {14'h0, rresp, rd_w}, rq.pop_front());
        if (bv === 1'b1 && br === 1'b1) check("bresp", {46'h0, bresp}, wq.pop_front());
    end
    // port values are looked at mid-cycle, where they have settled
    always @(negedge clk) begin
        while (pq.size() > 0) begin
            logic [49:0] n;
            n = pq.pop_front();
            case (n[49:48])
                2'h0: check("pulse_out_n", {45'h0, pout}, n[47:0]);
                2'h1: check("event_line_0_n", {47'h0, evn}, n[47:0]);
                default: check("path_pwr", ppw, n[47:0]);
            endcase
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic peek(input logic [1:0] s, input logic [47:0] e);
        pq.push_back({s, e});
    endtask : peek

    // =====================================================================
    // bus tasks; the closing idle edge keeps ready lines from double drives
    task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                      input logic [1:0] er = PESA_RESP_OK);
        bit a, w;
        a = 0;
        w = 0;
        wq.push_back({46'h0, er});
        awa <= {idx, 2'h0};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(a && w)) begin
            @(posedge clk);
            if (!a && awr === 1'b1) begin
                a = 1;
                awv <= 1'b0;
            end
            if (!w && wrd === 1'b1) begin
                w = 1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        br <= 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] d,
                      input logic [1:0] er = PESA_RESP_OK);
        rq.push_back({14'h0, er, d});
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rr <= 1'b0;
        tick(1);
    endtask : rd

    // falling then rising edge on the selected converter outputs
    task automatic fall(input logic [2:0] m);
        conv <= ~m;
        tick(3);
        conv <= 3'h7;
        tick(3);
    endtask : fall

    // expected contribution of one sample; rg selects register or pulse path
    function automatic int adj(input int t, input logic [1:0] m, input int v, input bit an,
                               input bit rg);
        if (t == 0 && m == PESA_M_POS && rg) return (v > 0) ? v : 0;
        if (t == 1 && m == PESA_M_ADJ) return an ? -v : v;
        if (t < 2 && m == PESA_M_ABS) return (v < 0) ? -v : v;
        return v;
    endfunction : adj

    // =====================================================================
    initial begin
        void'($urandom(14));
        tick(4);
        rstn <= 1'b1;
        tick(1);
        peek(0, 48'h7);
        conv <= 3'h7;
        rd(PESA_IDX_PCFG, 32'h0E88);
        rd(PESA_IDX_COMP, 32'h1FF);
        rd(PESA_IDX_ACCUMULATION_MODE_SELECT, 32'h0);
        rd(PESA_IDX_LATCH, 32'h0);
        rd(PESA_IDX_FLAGS, 32'h0);
        rd(PESA_IDX_SIGN, 32'h0);
        rd(16'h0000, 32'h0, PESA_RESP_ERR);
        wr(16'h0000, 32'hFFFF, PESA_RESP_ERR);
        // every mode code, even codes on active/reactive and odd codes on fundamental active/reactive, pins disabled, random phase include
        for (int m = 0; m < 4; m++) begin
            int a[3], q[3], s[3], ea[3], eq[3], es[3];
            int e1, e2, e3, t1;
            bit an[3];
            logic [1:0] mm;
            logic [8:0] cm;
            mm = 2'(m);
            t1 = m[0] ? 3 : 0;
            cm = 9'($urandom_range(0, 511));
            wr(PESA_IDX_ACCUMULATION_MODE_SELECT, {28'h0, mm, mm});
            rd(PESA_IDX_ACCUMULATION_MODE_SELECT, {28'h0, mm, mm});
            wr(PESA_IDX_COMP, {23'h0, cm});
            wr(PESA_IDX_PCFG, m[0] ? 32'h7EA3 : 32'h7E88);
            fall(3'h7);
            ea = '{0, 0, 0};
            eq = '{0, 0, 0};
            es = '{0, 0, 0};
            for (int k = 0; k < 2; k++) begin
                for (int p = 0; p < 3; p++) begin
                    a[p] = $urandom_range(0, 16000);
                    a[p] = (a[p] - 8000) * 256;
                    q[p] = $urandom_range(0, 16000);
                    q[p] = (q[p] - 8000) * 256;
                    s[p] = $urandom_range(0, 8000) * 256;
                    an[p] = (a[p] < 0) && ($urandom_range(0, 3) != 0);
                    idle[p] <= (a[p] < 0) && !an[p];
                    for (int t = 0; t < 5; t++) begin
                        pwr[(t * 3 + p) * 24 +: 24] <= 24'((t % 3 == 0) ? a[p] :
                                                          (t % 3 == 1) ? q[p] : s[p]);
                    end
                    ea[p] += adj(0, mm, a[p], 1'b0, 1'b1);
                    eq[p] += adj(1, mm, q[p], an[p], 1'b1);
                    es[p] += s[p];
                end
                pv <= 1'b1;
                tick(1);
                pv <= 1'b0;
                tick(2);
            end
            e1 = 0;
            e2 = 0;
            e3 = 0;
            for (int p = 0; p < 3; p++) begin
                if (cm[p]) e1 += adj(0, mm, a[p] >>> 8, 1'b0, 1'b0);
                if (cm[3 + p]) e2 += adj(1, mm, q[p] >>> 8, an[p], 1'b0);
                if (cm[6 + p]) e3 += s[p] >>> 8;
            end
            peek(2, {16'(e3), 16'(e2), 16'(e1)});
            fall(3'h7);
            for (int p = 0; p < 3; p++) begin
                rd(PESA_IDX_HOUR0 + 16'(t1 * 3 + p), 32'(ea[p]));
                rd(PESA_IDX_HOUR0 + 16'((t1 + 1) * 3 + p), 32'(eq[p]));
                rd(PESA_IDX_HOUR0 + 16'(6 + p), 32'(es[p]));
            end
            kept[t1] = ea[0];
        end
        // latch on the third edge only; written while outputs are quiet
        // write between edges
        wr(PESA_IDX_LATCH, 32'h3);
        for (int p = 0; p < 15; p++) pwr[p * 24 +: 24] <= 24'h000100;
        // the first sample meets a low clock enable and must be dropped
        ce <= 1'b0;
        pv <= 1'b1;
        tick(1);
        ce <= 1'b1;
        tick(1);
        pv <= 1'b0;
        fall(3'h1);
        fall(3'h1);
        rd(PESA_IDX_HOUR0 + 16'h9, 32'(kept[3]));
        fall(3'h1);
        rd(PESA_IDX_HOUR0 + 16'h9, 32'h100);
        // latch off, pins live: no capture, pins follow the converter
        wr(PESA_IDX_LATCH, 32'h0);
        wr(PESA_IDX_PCFG, 32'h0088);
        conv <= 3'h2;
        tick(1);
        // the pin is looked at mid-cycle, so the level must stand past it
        peek(0, 48'h2);
        tick(1);
        conv <= 3'h7;
        pv <= 1'b1;
        tick(1);
        pv <= 1'b0;
        fall(3'h7);
        rd(PESA_IDX_HOUR0, 32'(kept[0]));
        // sign change on all paths, only the first one enabled
        wr(PESA_IDX_ENABLE, 32'h200);
        neg <= 3'h7;
        hit <= 3'h7;
        tick(1);
        hit <= 3'h0;
        tick(2);
        peek(1, 48'h1);
        fall(3'h7);
        peek(1, 48'h0);
        rd(PESA_IDX_FLAGS, 32'h42200);
        rd(PESA_IDX_SIGN, 32'h188);
        wr(PESA_IDX_FLAGS, 32'h200);
        peek(1, 48'h1);
        rd(PESA_IDX_FLAGS, 32'h42000);
        rd(PESA_IDX_SIGN, 32'h188);
        wr(PESA_IDX_FLAGS, 32'h42000);
        rd(PESA_IDX_FLAGS, 32'h0);
        tick(2);
        report_and_stop();
    end
endmodule : testbench
